// ---- design/sdc_device.sv ----
// synthesizer divider control end: serial shift register, latches, loop control
// assumes link pins come from the host asynchronously; phase error is a pulse
// width input measured in core cycles
// What this block does
// (R1) host keeps if main count 3..4095
// (R2) if main not below swallow; 56..32767
// (R3) select bits 11 load rf main latch
// (R4) rf word: fine, middle, coarse, numerator fields
// (R5) host keeps coarse >= max(fine,middle)+2
// (R6) ratio = p*coarse + 4*middle + fine
// (R7) numerator 15 only with modulus 16
// (R8) low band: 24..39 partial, 40..16383 legal; code sets no upper limit, so low band ratios up to 16391 are flagged legal
// (R9) high band: 48..79 partial, 80..32767 legal
// (R10) band bit picks 8 or 16 modulus set
// (R11) clear bit holds loop counters in reset
// (R12) wake restarts n aligned to r
// (R13) sleep disables counters, inputs high impedance
// (R14) if reference off only when both sleep
// (R15) sleep floats charge pump and comparator
// (R16) serial register works during sleep
// (R17) synchronous sleep waits for pump pulse end
// (R18) asynchronous sleep acts immediately
// (R19) msb first, sampled on rising serial clock
// (R20) lock after 5 cycles of error <15 ns
// (R21) locked threshold widens to 30 ns
// (R22) sleeping loop forces lock low
// (R23) modulus bit picks 16 or 15
// (R24) latch-enable edge loads word by select
module sdc_device
  import sdc_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  sdc_link_if.dev link, // serial link from host
  input wire logic rf_ref_tick, // rf reference cycle pulse
  input wire logic if_ref_tick, // if reference cycle pulse
  input wire logic rf_pump_busy, // rf charge pump pulse in progress
  input wire logic if_pump_busy, // if charge pump pulse in progress
  input wire logic [7:0] rf_phase_err, // rf phase error, core cycles
  input wire logic [7:0] if_phase_err, // if phase error, core cycles
  output logic [14:0] rf_ratio, // rf integer ratio
  output logic [3:0] fraction_numerator, // rf fraction numerator
  output logic fraction_modulus_select, // 1: modulus 16
  output logic [4:0] rf_modulus, // prescaler base modulus
  output logic rf_ratio_legal, // rf word is a legal ratio
  output logic [14:0] if_ratio, // if integer ratio
  output logic if_ratio_legal, // if word is legal
  output logic rf_counter_hold, // rf n and r counters held
  output logic if_counter_hold, // if n and r counters held
  output logic rf_asleep, // rf loop powered down, inputs and pump floated
  output logic if_asleep, // if loop powered down, inputs and pump floated
  output logic if_ref_float, // if reference input floated
  output logic rf_restart, // pulse: restart rf n aligned to r
  output logic if_restart, // pulse: restart if n aligned to r
  output logic lock_indicator_output // both loops locked
);
  import sdc_pkg::*;

  // ************************************
  // link sampling
  // ************************************
  logic [2:0] sck_s1_q, sck_s2_q;
  logic sck_prev_q, le_prev_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s1_q <= 3'h0;
      sck_s2_q <= 3'h0;
      sck_prev_q <= 1'b0;
      le_prev_q <= 1'b0;
    end else begin
      sck_s1_q <= {link.le, link.sdata, link.sck};
      sck_s2_q <= sck_s1_q;
      sck_prev_q <= sck_s2_q[0];
      le_prev_q <= sck_s2_q[2];
    end
  end
  logic sck_rise, le_rise;
  assign sck_rise = sck_s2_q[0] & ~sck_prev_q;
  assign le_rise = sck_s2_q[2] & ~le_prev_q;

  // ************************************
  // shift register and latches
  // ************************************
  logic [WORD_W-1:0] shift_q, rf_main_divider_word_q, if_n_word_q, if_r_word_q;
  // shifting never looks at sleep state, so words load in every sleep mode
  always_ff @(posedge core_clk or negedge rst_n) begin // R16
    if (!rst_n) shift_q <= RESET_WORD;
    else if (sck_rise) shift_q <= {shift_q[WORD_W-2:0], sck_s2_q[1]}; // R19
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_main_divider_word_q <= RESET_WORD;
      if_n_word_q <= RESET_WORD;
      if_r_word_q <= RESET_WORD;
    end else if (le_rise) begin // R24
      case (shift_q[CTL_W-1:0])
        SEL_RF_N: rf_main_divider_word_q <= shift_q; // R3
        SEL_IF_N: if_n_word_q <= shift_q;
        SEL_IF_R: if_r_word_q <= shift_q;
        default: ;
      endcase
    end
  end

  // ************************************
  // divider decode
  // ************************************
  logic [10:0] coarse;
  logic [1:0] middle, fine;
  logic [3:0] numer;
  logic band;
  logic [11:0] if_main;
  logic [2:0] if_swallow;
  assign coarse = rf_main_divider_word_q[RF_COARSE_LSB +: 11]; // R4
  assign middle = rf_main_divider_word_q[RF_MIDDLE_LSB +: 2];
  assign fine = rf_main_divider_word_q[RF_FINE_LSB +: 2];
  assign numer = rf_main_divider_word_q[RF_FRAC_LSB +: 4];
  assign band = rf_main_divider_word_q[RF_BAND_BIT];
  assign if_main = if_n_word_q[IF_MAIN_LSB +: 12];
  assign if_swallow = if_n_word_q[IF_SWALLOW_LSB +: 3];

  logic [4:0] modulus;
  logic [15:0] ratio_wide;
  logic [1:0] big;
  assign modulus = band ? MOD_HIGH : MOD_LOW; // R10
  // widen before the product so the high band with a large coarse count cannot wrap
  assign ratio_wide = 16'(modulus) * 16'(coarse) + 16'({middle, 2'b00}) + 16'(fine); // R6
  assign big = (middle > fine) ? middle : fine;
  logic rf_ok, if_ok;
  logic [15:0] if_wide;
  assign if_wide = 16'({if_main, 3'b000}) + 16'(if_swallow);
  // coarse margin alone lets some ratios below 24 or 48 through, so the band minimum is checked too; partial range is not checked
  assign rf_ok = (32'(coarse) >= 32'(big) + RF_COARSE_MARGIN) // R5 R8 R9
    && (band ? ratio_wide >= 16'(RF_HIGH_MIN) : ratio_wide >= 16'(RF_LOW_MIN))
    && (fraction_ok(numer, if_r_word_q[IF_R_MOD_BIT])); // R7
  assign if_ok = (32'(if_main) >= IF_MAIN_MIN) && (12'(if_swallow) <= if_main) // R1 R2
    && (32'(if_wide) >= IF_TOTAL_MIN);

  function automatic logic fraction_ok(input logic [3:0] n, input logic m16);
    fraction_ok = m16 || (n <= FRAC_MAX15);
  endfunction : fraction_ok

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_ratio <= 15'h0000;
      fraction_numerator <= 4'h0;
      fraction_modulus_select <= 1'b0;
      rf_modulus <= MOD_LOW;
      rf_ratio_legal <= 1'b0;
      if_ratio <= 15'h0000;
      if_ratio_legal <= 1'b0;
      rf_counter_hold <= 1'b0;
      if_counter_hold <= 1'b0;
    end else begin
      rf_ratio <= ratio_wide[14:0];
      fraction_numerator <= numer;
      fraction_modulus_select <= if_r_word_q[IF_R_MOD_BIT]; // R23
      rf_modulus <= modulus;
      rf_ratio_legal <= rf_ok;
      if_ratio <= if_wide[14:0];
      if_ratio_legal <= if_ok;
      rf_counter_hold <= rf_main_divider_word_q[RF_CLEAR_BIT]; // R11
      if_counter_hold <= if_n_word_q[IF_CLEAR_BIT]; // R11
    end
  end

  // ************************************
  // power down sequencing
  // ************************************
  logic sync_mode, rf_req, if_req;
  assign sync_mode = if_n_word_q[IF_TIMING_BIT];
  assign rf_req = rf_main_divider_word_q[RF_SLEEP_BIT];
  assign if_req = if_n_word_q[IF_SLEEP_BIT];
  always_ff @(posedge core_clk or negedge rst_n) begin // R13 R15
    if (!rst_n) begin
      rf_asleep <= 1'b0;
      if_asleep <= 1'b0;
    end else begin
      // sync mode holds off while a pump pulse runs, so no half pulse is cut
      if (!rf_req) rf_asleep <= 1'b0;
      else if (!sync_mode || !rf_pump_busy) rf_asleep <= 1'b1; // R17 R18
      if (!if_req) if_asleep <= 1'b0;
      else if (!sync_mode || !if_pump_busy) if_asleep <= 1'b1; // R17 R18
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      if_ref_float <= 1'b0;
      rf_restart <= 1'b0;
      if_restart <= 1'b0;
    end else begin
      if_ref_float <= rf_asleep & if_asleep; // R14
      rf_restart <= rf_asleep & ~rf_req; // R12
      if_restart <= if_asleep & ~if_req; // R12
    end
  end

  // ************************************
  // lock filters
  // ************************************
  localparam int unsigned ENTER_CYC = (LOCK_ENTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned EXIT_CYC = (LOCK_EXIT_NS + CLK_NS - 1) / CLK_NS;
  logic [1:0] tick, sleep_v;
  // one element per loop, so each generated process owns its own variable
  logic locked_q [2];
  logic [7:0] err [2];
  logic [2:0] good_q [2];
  assign tick = {if_ref_tick, rf_ref_tick};
  assign sleep_v = {if_asleep, rf_asleep};
  assign err[0] = rf_phase_err;
  assign err[1] = if_phase_err;
  for (genvar g = 0; g < 2; g++) begin : g_lock
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        good_q[g] <= 3'h0;
        locked_q[g] <= 1'b0;
      end else if (sleep_v[g]) begin // R22
        good_q[g] <= 3'h0;
        locked_q[g] <= 1'b0;
      end else if (tick[g]) begin
        if (locked_q[g]) begin
          if (32'(err[g]) > EXIT_CYC) begin // R21
            locked_q[g] <= 1'b0;
            good_q[g] <= 3'h0;
          end
        end else if (32'(err[g]) < ENTER_CYC) begin
          if (32'(good_q[g]) + 1 >= LOCK_CYCLES) locked_q[g] <= 1'b1; // R20
          else good_q[g] <= good_q[g] + 3'h1;
        end else begin
          good_q[g] <= 3'h0;
        end
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) lock_indicator_output <= 1'b0;
    else lock_indicator_output <= locked_q[0] & locked_q[1]; // R22
  end
endmodule : sdc_device

// ---- design/sdc_host.sv ----
// host end: shifts 24-bit words msb first and pulses latch enable
// assumes software uses the plain register port; offsets below are block-local
module sdc_host
  import sdc_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  sdc_link_if.host link, // serial link to device
  input wire logic [1:0] addr, // register index
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata // read data, cycle after rd
);
  import sdc_pkg::*;
  localparam logic [1:0] REG_WORD = 2'h0; // write starts a transfer
  localparam logic [1:0] REG_STAT = 2'h1; // bit0 busy, bit1 done sticky
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_LATCH} sdc_state_t;
  sdc_state_t st_q;
  logic [WORD_W-1:0] word_q;
  logic [4:0] bit_q;
  logic [2:0] div_q;
  logic done_q;
  logic tick;
  assign tick = (32'(div_q) == SCK_HALF - 1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) div_q <= 3'h0;
    else if (st_q == ST_IDLE || tick) div_q <= 3'h0;
    else div_q <= div_q + 3'h1;
  end

  // ************************************
  // serial engine
  // ************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      word_q <= RESET_WORD;
      bit_q <= 5'h00;
      link.sck <= 1'b0;
      link.sdata <= 1'b0;
      link.le <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (wr && addr == REG_WORD) begin // R24
            word_q <= wdata[WORD_W-1:0];
            link.sdata <= wdata[WORD_W-1]; // R19
            bit_q <= 5'h00;
            st_q <= ST_LOW;
          end
        end
        ST_LOW: if (tick) begin
          link.sck <= 1'b1;
          st_q <= ST_HIGH;
        end
        ST_HIGH: if (tick) begin
          link.sck <= 1'b0;
          if (32'(bit_q) == WORD_W - 1) begin
            link.le <= 1'b1;
            st_q <= ST_LATCH;
          end else begin
            word_q <= {word_q[WORD_W-2:0], 1'b0};
            link.sdata <= word_q[WORD_W-2];
            bit_q <= bit_q + 5'h01;
            st_q <= ST_LOW;
          end
        end
        ST_LATCH: if (tick) begin
          link.le <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // set wins over clear of the done flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) done_q <= 1'b0;
    else if (st_q == ST_LATCH && tick) done_q <= 1'b1;
    else if (rd && addr == REG_STAT) done_q <= 1'b0;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rdata <= 32'h00000000;
    else if (rd && addr == REG_STAT) rdata <= {30'h0, done_q, st_q != ST_IDLE};
    else rdata <= 32'h00000000;
  end
endmodule : sdc_host

// ---- design/sdc_link_if.sv ----
// three-wire serial programming link between host and synthesizer control
// assumes both ends run on the same core clock
interface sdc_link_if;
  logic sck; // serial clock, made by host
  logic sdata; // serial data, msb first
  logic le; // latch enable
  modport host (output sck, output sdata, output le);
  modport dev (input sck, input sdata, input le);
endinterface : sdc_link_if

// ---- design/sdc_pkg.sv ----
// package for the synthesizer divider control link and both of its ends
// assumes a single core clock domain; the serial link is sampled, not clocked
package sdc_pkg;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned CTL_W = 2;
  // latch select codes in the two lowest word bits
  localparam logic [1:0] SEL_IF_R = 2'h0;
  localparam logic [1:0] SEL_IF_N = 2'h1;
  localparam logic [1:0] SEL_RF_R = 2'h2;
  localparam logic [1:0] SEL_RF_N = 2'h3;
  // rf main divider word fields
  localparam int unsigned RF_CLEAR_BIT = 23;
  localparam int unsigned RF_SLEEP_BIT = 22;
  localparam int unsigned RF_BAND_BIT = 21;
  localparam int unsigned RF_COARSE_LSB = 10;
  localparam int unsigned RF_MIDDLE_LSB = 8;
  localparam int unsigned RF_FINE_LSB = 6;
  localparam int unsigned RF_FRAC_LSB = 2;
  // if main divider word fields
  localparam int unsigned IF_CLEAR_BIT = 23;
  localparam int unsigned IF_SLEEP_BIT = 22;
  localparam int unsigned IF_TIMING_BIT = 21;
  localparam int unsigned IF_MAIN_LSB = 5;
  localparam int unsigned IF_SWALLOW_LSB = 2;
  // if reference word
  localparam int unsigned IF_R_MOD_BIT = 22;
  // legality limits
  localparam int unsigned IF_MAIN_MIN = 3;
  localparam int unsigned IF_TOTAL_MIN = 56;
  localparam int unsigned RF_LOW_MIN = 24;
  localparam int unsigned RF_LOW_FULL = 40;
  localparam int unsigned RF_HIGH_MIN = 48;
  localparam int unsigned RF_HIGH_FULL = 80;
  localparam int unsigned RF_COARSE_MARGIN = 2;
  localparam logic [4:0] MOD_LOW = 5'h08;
  localparam logic [4:0] MOD_HIGH = 5'h10;
  localparam logic [3:0] FRAC_MAX15 = 4'he;
  // lock filter timing
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned LOCK_ENTER_NS = 15;
  localparam int unsigned LOCK_EXIT_NS = 30;
  localparam int unsigned LOCK_CYCLES = 5;
  // serial clock divider at the host: half period in core cycles
  localparam int unsigned SCK_HALF = 4;
  localparam logic [23:0] RESET_WORD = 24'h000000;
endpackage : sdc_pkg

// ---- dv/sdc_link_monitor.sv ----
// wire-level checker for the serial programming link
// assumes one core clock domain; sees only the link signals as plain inputs
module sdc_link_monitor
  import sdc_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic sck, // serial clock from host
  input wire logic sdata, // serial data
  input wire logic le // latch enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // rising serial clock edges since the last latch pulse
  // ****
  int unsigned rise_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt <= 0;
    end else if ($fell(le)) begin
      rise_cnt <= 0;
    end else if ($rose(sck)) begin
      rise_cnt <= rise_cnt + 1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_high_half;
    sck [*4];
  endsequence
  sequence s_low_half;
    !sck [*4];
  endsequence
  a_sck_high_half: assert property ($rose(sck) |-> s_high_half ##1 !sck)
    else $error("serial clock high phase wrong");
  a_sck_low_half: assert property ($fell(sck) && rise_cnt < WORD_W |-> s_low_half ##1 sck)
    else $error("serial clock low phase wrong");
  a_data_steady: assert property (sck && $past(sck) |-> $stable(sdata))
    else $error("data moved while serial clock high");
  a_data_setup: assert property ($rose(sck) |-> $stable(sdata))
    else $error("data moved at serial clock rise");
  a_le_width: assert property ($rose(le) |-> le [*4] ##1 !le)
    else $error("latch pulse width wrong");
  a_le_sck_low: assert property (le |-> !sck)
    else $error("serial clock high during latch");
  a_word_bits: assert property ($rose(le) |-> rise_cnt == WORD_W)
    else $error("latch after wrong bit count");
  a_sck_quiet: assert property (rise_cnt == WORD_W |-> !$rose(sck))
    else $error("extra serial clock after full word");
endmodule : sdc_link_monitor

// ---- dv/testbench.sv ----
// self-checking bench: host and device joined by the link interface
// assumes host register index 0 takes a word and index 1 gives busy in bit 0
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sdc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, v;
  logic wr = 1'b0, rd = 1'b0, tick = 1'b0, rf_busy = 1'b0, if_busy = 1'b0;
  logic [7:0] perr = 8'h00;
  logic [14:0] rf_ratio, if_ratio;
  logic [3:0] fnum;
  logic [4:0] rmod;
  logic fmod, rleg, ileg, rhold, ihold, rsl, isl, ifl, rrs, irs, lock;
  int bad_count = 0, samples_checked = 0, restarts = 0;
  always #25 core_clk = ~core_clk;
  sdc_link_if link();
  sdc_host sdc_host_inst(.core_clk(core_clk), .rst_n(rst_n), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  sdc_device sdc_device_inst(.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .rf_ref_tick(tick), .if_ref_tick(tick), .rf_pump_busy(rf_busy), .if_pump_busy(if_busy),
    .rf_phase_err(perr), .if_phase_err(perr), .rf_ratio(rf_ratio), .fraction_numerator(fnum),
    .fraction_modulus_select(fmod), .rf_modulus(rmod), .rf_ratio_legal(rleg),
    .if_ratio(if_ratio), .if_ratio_legal(ileg), .rf_counter_hold(rhold),
    .if_counter_hold(ihold), .rf_asleep(rsl), .if_asleep(isl), .if_ref_float(ifl),
    .rf_restart(rrs), .if_restart(irs), .lock_indicator_output(lock));
  sdc_link_monitor sdc_link_monitor_inst(.core_clk(core_clk), .rst_n(rst_n),
    .sck(link.sck), .sdata(link.sdata), .le(link.le));
  always @(posedge core_clk) if (rrs === 1'b1 || irs === 1'b1) restarts <= restarts + 1;
  // ****
  // access and compare tasks
  // ****
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic rd_reg(input logic [1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // busy is polled so the next word never lands while the host still shifts
  task automatic send(input logic [23:0] w);
    logic [31:0] s;
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= 2'h0;
    wdata <= {8'h00, w};
    @(posedge core_clk);
    wr <= 1'b0;
    s = 32'h1;
    for (int i = 0; i < 400 && s[0] !== 1'b0; i++) rd_reg(2'h1, s);
    if (s[0] !== 1'b0) begin
      bad_count++;
      print_verdict();
    end
    chk("status", 32'h2, s);
    repeat (8) @(posedge core_clk);
  endtask : send
  task automatic rfw(input int c, m, f, n, b, clr, sl, lg);
    send({clr[0], sl[0], b[0], c[10:0], m[1:0], f[1:0], n[3:0], SEL_RF_N});
    chk("rf", {15'((b ? 16 : 8) * c + 4 * m + f), n[3:0], 5'(b ? 16 : 8), lg[0], clr[0],
      sl[0]}, {5'h0, rf_ratio, fnum, rmod, rleg, rhold, rsl});
  endtask : rfw
  task automatic ifw(input int mn, sw, tm, sl, clr, lg, asl);
    send({clr[0], sl[0], tm[0], 4'h0, mn[11:0], sw[2:0], SEL_IF_N});
    chk("if", {15'(8 * mn + sw), lg[0], clr[0], asl[0]},
      {if_ratio, ileg, ihold, isl});
  endtask : ifw
  task automatic ticks(input int n, input logic [7:0] e, input logic exp);
    repeat (n) begin
      @(posedge core_clk);
      tick <= 1'b1;
      perr <= e;
      @(posedge core_clk);
      tick <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    chk("lock", {31'h0, exp}, {31'h0, lock});
  endtask : ticks
  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_reg(2'h3, v);
    chk("unmapped", 32'h0, v);
    rfw(10, 2, 3, 14, 0, 0, 0, 1);
    rfw(10, 2, 3, 14, 1, 0, 0, 1);
    rfw(3, 0, 0, 0, 0, 0, 0, 1);
    rfw(2, 0, 0, 0, 0, 0, 0, 0);
    rfw(3, 0, 0, 0, 1, 0, 0, 1);
    rfw(4, 3, 0, 0, 0, 0, 0, 0);
    rfw(5, 3, 3, 15, 0, 1, 0, 0);
    send(24'h400000);
    chk("modulus16", 32'h1, {31'h0, fmod});
    rfw(5, 3, 3, 15, 0, 0, 0, 1);
    $display("rf divider test done");
    ifw(7, 0, 0, 0, 0, 1, 0);
    ifw(6, 7, 0, 0, 0, 0, 0);
    ifw(2, 0, 0, 0, 1, 0, 0);
    ifw(4095, 7, 0, 0, 0, 1, 0);
    ifw(7, 0, 0, 1, 0, 1, 1);
    chk("ref float", 32'h0, {31'h0, ifl});
    rfw(40, 0, 0, 0, 0, 0, 1, 1);
    chk("ref float", 32'h1, {31'h0, ifl});
    ifw(7, 0, 0, 0, 0, 1, 0);
    rfw(40, 0, 0, 0, 0, 0, 0, 1);
    chk("restarts", 32'd2, restarts);
    ifw(7, 0, 1, 0, 0, 1, 0);
    if_busy <= 1'b1;
    ifw(7, 0, 1, 1, 0, 1, 0);
    if_busy <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("sync sleep", 32'h1, {31'h0, isl});
    ifw(7, 0, 1, 0, 0, 1, 0);
    chk("restarts", 32'd3, restarts);
    $display("sleep test done");
    ticks(4, 8'h00, 1'b0);
    ticks(1, 8'h01, 1'b0);
    ticks(4, 8'h00, 1'b0);
    ticks(1, 8'h00, 1'b1);
    ticks(1, 8'h01, 1'b1);
    ticks(1, 8'h02, 1'b0);
    ticks(5, 8'h00, 1'b1);
    rfw(40, 0, 0, 0, 0, 0, 1, 1);
    chk("lock asleep", 32'h0, {31'h0, lock});
    $display("lock test done");
    print_verdict();
  end
endmodule : testbench
